//--- include/drac_pkg.sv
// Package of constants and types for the DRAM refresh and access controller
`default_nettype none
package drac_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] DIV_L01 = 8'h1f;  // 31
  localparam logic [7:0] DIV_L10 = 8'h2e;  // 46
  localparam logic [7:0] DIV_L11 = 8'h3d;  // 61
  localparam logic [7:0] DIV_H00 = 8'h2e;  // 46
  localparam logic [7:0] DIV_H01 = 8'h3d;  // 61
  localparam logic [7:0] DIV_H10 = 8'h4c;  // 76
  localparam logic [7:0] DIV_H11 = 8'h5b;  // 91
  localparam logic [7:0] REF_ROW_LOAD = 8'hff;
  localparam logic [7:0] REF_ROW_RESET = 8'hff;
  localparam logic [3:0] REF_CYC_LEN = 4'h4;  // Clocks each refresh holds the row strobes
  localparam logic [3:0] ARB_LAT_CYC = 4'hc;  // Worst arbitration latency when cycles collide
  localparam logic [1:0] WAIT_ONE = 2'h1;
  typedef enum logic [2:0] {
    DRAC_IDLE,
    DRAC_ROW,
    DRAC_COL,
    DRAC_REF
  } drac_state_e;
endpackage : drac_pkg
`default_nettype wire

//--- hw/drac_ref_timer.sv
// Refresh rate divider selected by the straps
`timescale 1ns/10ps
`default_nettype none
module drac_ref_timer (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       clr,
  input  wire logic       wait_strap,
  input  wire logic [1:0] freq_sel,
  output var  logic       expire
);
  import drac_pkg::*;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] div;
  logic       expire_next;

  // ==========================================================
  // Divider selection and count
  always_comb begin
    case ({wait_strap, freq_sel})
      3'h1:    div = DIV_L01;
      3'h2:    div = DIV_L10;
      3'h3:    div = DIV_L11;
      3'h4:    div = DIV_H00;
      3'h5:    div = DIV_H01;
      3'h6:    div = DIV_H10;
      3'h7:    div = DIV_H11;
      default: div = 8'h00;
    endcase
    cnt_next    = cnt_reg + 8'h01;
    expire_next = 1'b0;
    // All straps low means external refresh only: timer held
    if (clr || div == 8'h00) begin
      cnt_next = 8'h00;
    end else if (cnt_reg == div - 8'h01) begin
      cnt_next    = 8'h00;
      expire_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_reg <= 8'h00;
      expire  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      expire  <= expire_next;
    end
  end
endmodule : drac_ref_timer
`default_nettype wire

//--- hw/drac_ctrl.sv
// DRAM refresh and access controller top level
//
// Function
// - Sixteen address bits multiplexed onto eight outputs, row then column.
// - Eight-bit refresh counter walks all 256 rows.
// - Row from row inputs, column from column inputs.
// - With chip select, bank select low picks row strobe 0, high picks 1.
// - Latch enable high makes address outputs follow row inputs.
// - Either access control low shows column and asserts column strobe.
// - Access control rising ends cycle, dropping row and column strobes.
// - Both access controls low float address and strobe outputs.
// - External falling refresh request starts refresh, resets timer.
// - Timer expiry pulls request low until refresh row is on outputs.
// - Refresh asserts both row strobes.
// - Ready stretches slow accesses and holds off accesses during refresh.
// - Wait strap high adds one wait state per access.
// - Wait strap low divides clock by 31, 46 or 61.
// - Wait strap high divides clock by 46, 61, 76 or 91.
// - All straps low: external refresh only, timer held reset.
// - Timer resets on refresh request or all straps low.
// - Refresh row counter decrements after each refresh.
// - Wait strap rising loads refresh row counter with all ones.
// - Arbitrate pending requests against running cycles, schedule the held one.
// - Cycles start on the clock edge; latch enable should avoid it.
// - Latch enable rising with refresh pending starts a refresh next edge.
`timescale 1ns/10ps
`default_nettype none
module drac_ctrl (
  input  wire logic                        clock,
  input  wire logic                        srst,
  input  wire logic [drac_pkg::ADDR_W-1:0] row_addr_in,
  input  wire logic [drac_pkg::ADDR_W-1:0] col_addr_in,
  input  wire logic                        chip_sel_n,
  input  wire logic                        bank_select,
  input  wire logic                        addr_latch_en,
  input  wire logic                        read_access_ctl_n,
  input  wire logic                        write_access_ctl_n,
  input  wire logic                        refresh_request_line_in,
  input  wire logic                        wait_strap,
  input  wire logic                        freq_select_0,
  input  wire logic                        freq_select_1,
  output var  logic [drac_pkg::ADDR_W-1:0] mem_addr_out,
  output var  logic                        mem_addr_oe,
  output var  logic                        row_strobe_0_n,
  output var  logic                        row_strobe_1_n,
  output var  logic                        col_strobe_n,
  output var  logic                        strobe_oe,
  output var  logic                        refresh_request_line_out,
  output var  logic                        refresh_request_line_oe,
  output var  logic                        ready
);
  import drac_pkg::*;

  // ==========================================================
  // Strap and input sampling
  logic       wait_reg, wait_next;
  logic [1:0] fs_reg, fs_next;
  logic       wait_d_reg;
  logic       rq_d_reg, rq_next;
  logic       ale_d_reg, ale_next;
  logic       acx_d_reg, acx_next;
  logic [7:0] row_lat_reg, row_lat_next;
  logic       bank_reg, bank_next;
  logic       cs_reg, cs_next;

  // Straps registered so mode changes land on a clock edge
  always_comb begin
    wait_next    = wait_strap;
    fs_next      = {freq_select_1, freq_select_0};
    rq_next      = refresh_request_line_in;
    ale_next     = addr_latch_en;
    acx_next     = read_access_ctl_n & write_access_ctl_n;
    row_lat_next = row_lat_reg;
    bank_next    = bank_reg;
    cs_next      = cs_reg;
    // Transparent latch: follows while enable high, holds after
    if (addr_latch_en) begin
      row_lat_next = row_addr_in;
      bank_next    = bank_select;
      cs_next      = ~chip_sel_n;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wait_reg    <= 1'b0;
      fs_reg      <= 2'h0;
      wait_d_reg  <= 1'b0;
      rq_d_reg    <= 1'b1;
      ale_d_reg   <= 1'b0;
      acx_d_reg   <= 1'b1;
      row_lat_reg <= 8'h00;
      bank_reg    <= 1'b0;
      cs_reg      <= 1'b0;
    end else begin
      wait_reg    <= wait_next;
      fs_reg      <= fs_next;
      wait_d_reg  <= wait_reg;
      rq_d_reg    <= rq_next;
      ale_d_reg   <= ale_next;
      acx_d_reg   <= acx_next;
      row_lat_reg <= row_lat_next;
      bank_reg    <= bank_next;
      cs_reg      <= cs_next;
    end
  end

  logic acx_low;
  logic both_low;
  logic acx_rise;
  logic ext_req_fall;
  logic ale_rise;
  assign acx_low      = ~(read_access_ctl_n & write_access_ctl_n);
  assign both_low     = ~read_access_ctl_n & ~write_access_ctl_n;
  assign acx_rise     = ~acx_d_reg & ~acx_low;
  assign ext_req_fall = rq_d_reg & ~refresh_request_line_in & ~refresh_request_line_oe;  // Own pull masked
  assign ale_rise     = ~ale_d_reg & addr_latch_en;

  // ==========================================================
  // Refresh timer
  logic timer_expire;
  logic timer_clr;
  // Outside requests restart the timer; its own expiry already wraps it to zero,
  // so holding it clear while we pull the line would stretch the period
  assign timer_clr = ext_req_fall;

  drac_ref_timer u_timer (
    .clock      (clock),
    .srst       (srst),
    .clr        (timer_clr),
    .wait_strap (wait_reg),
    .freq_sel   (fs_reg),
    .expire     (timer_expire)
  );

  // ==========================================================
  // Arbiter and cycle sequencer
  drac_state_e state_reg, state_next;
  logic       ref_pend_reg, ref_pend_next;
  logic       int_req_reg, int_req_next;
  logic [7:0] ref_row_reg, ref_row_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] wst_reg, wst_next;
  logic       acc_held_reg, acc_held_next;
  logic       ref_go;

  // Refresh wins only if requested before an access began (cycle steal)
  assign ref_go = ref_pend_reg & (~acx_low | ale_rise);

  always_comb begin
    state_next    = state_reg;
    ref_pend_next = ref_pend_reg;
    int_req_next  = int_req_reg;
    ref_row_next  = ref_row_reg;
    cnt_next      = cnt_reg;
    wst_next      = wst_reg;
    acc_held_next = acc_held_reg;
    // Pending set wins over the clear that starts the refresh
    if (timer_expire) begin
      int_req_next = 1'b1;
    end
    if (timer_expire || ext_req_fall) begin
      ref_pend_next = 1'b1;
    end
    if (wait_reg && !wait_d_reg) begin
      ref_row_next = REF_ROW_LOAD;
    end
    case (state_reg)
      DRAC_IDLE: begin
        // Refresh on ALE rise ahead of access control, else access
        if (ref_go && (ale_rise || !acx_low)) begin
          state_next    = DRAC_REF;
          cnt_next      = REF_CYC_LEN;
          ref_pend_next = timer_expire | ext_req_fall;
          // An access latched on this edge waits behind the refresh
          acc_held_next = acc_held_reg | (cs_next & addr_latch_en);
        end else if ((cs_next && addr_latch_en) || (acc_held_reg && cs_reg)) begin
          state_next    = DRAC_ROW;
          acc_held_next = 1'b0;
        end
      end
      DRAC_ROW: begin
        if (acx_low) begin
          state_next = DRAC_COL;
          wst_next   = wait_reg ? WAIT_ONE : 2'h0;
        end else if (!cs_reg) begin
          state_next = DRAC_IDLE;
        end
      end
      DRAC_COL: begin
        if (wst_reg != 2'h0) begin
          wst_next = wst_reg - 2'h1;
        end
        if (acx_rise) begin
          state_next = DRAC_IDLE;
        end
      end
      DRAC_REF: begin
        int_req_next  = timer_expire;  // Released once refresh row is out; a new expiry wins
        acc_held_next = acc_held_reg | acx_low | (cs_next & addr_latch_en);
        cnt_next      = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          ref_row_next = ref_row_reg - 8'h01;
          // One idle clock precharges the rows before a held-off access runs
          state_next   = DRAC_IDLE;
        end
      end
      default: state_next = DRAC_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg    <= DRAC_IDLE;
      ref_pend_reg <= 1'b0;
      int_req_reg  <= 1'b0;
      ref_row_reg  <= REF_ROW_RESET;
      cnt_reg      <= 4'h0;
      wst_reg      <= 2'h0;
      acc_held_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      ref_pend_reg <= ref_pend_next;
      int_req_reg  <= int_req_next;
      ref_row_reg  <= ref_row_next;
      cnt_reg      <= cnt_next;
      wst_reg      <= wst_next;
      acc_held_reg <= acc_held_next;
    end
  end

  // ==========================================================
  // Output stage, all registered
  logic [7:0] ma_next;
  logic       row_strobe_0_next, row_strobe_1_next, cas_next, oe_next, rdy_next;

  always_comb begin
    ma_next   = row_lat_next;
    row_strobe_0_next = 1'b1;
    row_strobe_1_next = 1'b1;
    cas_next  = 1'b1;
    oe_next   = ~both_low;
    rdy_next  = 1'b1;
    case (state_next)
      DRAC_ROW: begin
        row_strobe_0_next = bank_next;
        row_strobe_1_next = ~bank_next;
      end
      DRAC_COL: begin
        ma_next   = col_addr_in;
        row_strobe_0_next = bank_next;
        row_strobe_1_next = ~bank_next;
        cas_next  = 1'b0;
        rdy_next  = (wst_next == 2'h0);
      end
      DRAC_REF: begin
        ma_next   = ref_row_next;
        row_strobe_0_next = 1'b0;
        row_strobe_1_next = 1'b0;
        rdy_next  = ~acx_low;
      end
      default: begin
        ma_next  = row_lat_next;
        rdy_next = ~acc_held_next;  // Access waiting for its turn stays held off
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mem_addr_out             <= 8'h00;
      mem_addr_oe              <= 1'b0;
      row_strobe_0_n           <= 1'b1;
      row_strobe_1_n           <= 1'b1;
      col_strobe_n             <= 1'b1;
      strobe_oe                <= 1'b0;
      refresh_request_line_out <= 1'b0;
      refresh_request_line_oe  <= 1'b0;
      ready                    <= 1'b1;
    end else begin
      mem_addr_out             <= ma_next;
      mem_addr_oe              <= oe_next;
      row_strobe_0_n           <= row_strobe_0_next;
      row_strobe_1_n           <= row_strobe_1_next;
      col_strobe_n             <= cas_next;
      strobe_oe                <= oe_next;
      refresh_request_line_out <= 1'b0;  // Open drain: only ever pulls low
      refresh_request_line_oe  <= int_req_next;
      ready                    <= rdy_next;
    end
  end
endmodule : drac_ctrl
`default_nettype wire

//--- dv/drac_checker.sv
// Concurrent checks on the DRAM controller ports
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checker
module drac_checker (
  input wire logic                        clock,
  input wire logic                        srst,
  input wire logic [drac_pkg::ADDR_W-1:0] row_addr_in,
  input wire logic [drac_pkg::ADDR_W-1:0] col_addr_in,
  input wire logic                        chip_sel_n,
  input wire logic                        bank_select,
  input wire logic                        addr_latch_en,
  input wire logic                        read_access_ctl_n,
  input wire logic                        write_access_ctl_n,
  input wire logic                        wait_strap,
  input wire logic [drac_pkg::ADDR_W-1:0] mem_addr_out,
  input wire logic                        mem_addr_oe,
  input wire logic                        row_strobe_0_n,
  input wire logic                        row_strobe_1_n,
  input wire logic                        col_strobe_n,
  input wire logic                        strobe_oe,
  input wire logic                        refresh_request_line_oe,
  input wire logic                        ready
);
  import drac_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  // Access idle: neither row strobe active and both controls high
  sequence s_idle;
    read_access_ctl_n && write_access_ctl_n && row_strobe_0_n && row_strobe_1_n;
  endsequence
  // One stretched clock, then release
  sequence s_one_wait;
    !ready ##1 ready;
  endsequence
  property p_float;
    !read_access_ctl_n && !write_access_ctl_n |=> !mem_addr_oe && !strobe_oe;
  endproperty
  a_float: assert property (p_float) else $error("outputs still driven");
  // Refresh frames are excluded since they own the address lines
  property p_row;
    addr_latch_en && read_access_ctl_n && write_access_ctl_n ##1 (row_strobe_0_n || row_strobe_1_n)
      |-> mem_addr_out == $past(row_addr_in);
  endproperty
  a_row: assert property (p_row) else $error("row not passed through");
  property p_col;
    (read_access_ctl_n != write_access_ctl_n) && (row_strobe_0_n != row_strobe_1_n)
      |=> !col_strobe_n && mem_addr_out == $past(col_addr_in);
  endproperty
  a_col: assert property (p_col) else $error("column phase wrong");
  property p_bank0;
    s_idle and addr_latch_en && !chip_sel_n && !bank_select |=> !row_strobe_0_n;
  endproperty
  a_bank0: assert property (p_bank0) else $error("bank 0 strobe missing");
  property p_bank1;
    s_idle and addr_latch_en && !chip_sel_n && bank_select |=> !row_strobe_1_n;
  endproperty
  a_bank1: assert property (p_bank1) else $error("bank 1 strobe missing");
  property p_end;
    $rose(read_access_ctl_n) && write_access_ctl_n && !col_strobe_n
      |=> row_strobe_0_n && row_strobe_1_n && col_strobe_n;
  endproperty
  a_end: assert property (p_end) else $error("strobes not ended");
  property p_wait1;
    $fell(col_strobe_n) && wait_strap |-> s_one_wait;
  endproperty
  a_wait1: assert property (p_wait1) else $error("wait state missing");
  property p_wait0;
    $fell(col_strobe_n) && !wait_strap |-> ready;
  endproperty
  a_wait0: assert property (p_wait0) else $error("spurious wait state");
  // Request must turn into a two-bank refresh within the arbitration bound
  property p_ref;
    $rose(refresh_request_line_oe) |-> ##[0:12] (!row_strobe_0_n && !row_strobe_1_n);
  endproperty
  a_ref: assert property (p_ref) else $error("refresh did not start");
endmodule : drac_checker
bind drac_ctrl drac_checker u_chk (.clock, .srst, .row_addr_in, .col_addr_in, .chip_sel_n, .bank_select,
  .addr_latch_en, .read_access_ctl_n, .write_access_ctl_n, .wait_strap, .mem_addr_out, .mem_addr_oe,
  .row_strobe_0_n, .row_strobe_1_n, .col_strobe_n, .strobe_oe, .refresh_request_line_oe, .ready);
`default_nettype wire

//--- dv/drac_dram_model.sv
// Far-side model: two DRAM banks and the shared refresh request wire
`timescale 1ns/10ps
`default_nettype none
module drac_dram_model (
  input  wire logic                        clock,
  input  wire logic [drac_pkg::ADDR_W-1:0] mem_addr_out,
  input  wire logic                        mem_addr_oe,
  input  wire logic                        row_strobe_0_n,
  input  wire logic                        row_strobe_1_n,
  input  wire logic                        col_strobe_n,
  input  wire logic                        strobe_oe,
  input  wire logic                        refresh_request_line_out,
  input  wire logic                        refresh_request_line_oe,
  input  wire logic                        ext_pull,
  output wire logic                        refresh_request_line_in,
  output var  int                          ref_cnt,
  output var  logic [drac_pkg::ADDR_W-1:0] ref_row,
  output var  logic [drac_pkg::ADDR_W-1:0] acc_row,
  output var  logic [drac_pkg::ADDR_W-1:0] acc_col,
  output var  logic                        acc_bank
);
  import drac_pkg::*;
  logic [ADDR_W-1:0] addr_seen;
  logic [ADDR_W-1:0] addr_last = 8'h00;
  logic              r0;
  logic              r1;
  logic              cn;
  logic              p0 = 1'b1;
  logic              p1 = 1'b1;
  logic              pc = 1'b1;
  // Floated address reads back inverted so a stale copy never passes
  assign addr_seen = mem_addr_oe ? mem_addr_out : ~addr_last;
  // Strobe wires have pull-ups
  assign r0 = strobe_oe ? row_strobe_0_n : 1'b1;
  assign r1 = strobe_oe ? row_strobe_1_n : 1'b1;
  assign cn = strobe_oe ? col_strobe_n : 1'b1;
  // Open-drain wire with pull-up, pulled low by either party
  assign refresh_request_line_in = !((refresh_request_line_oe && !refresh_request_line_out) || ext_pull);
  initial ref_cnt = 0;
  // Latch addresses as the banks would on strobe falls
  always @(posedge clock) begin
    p0 <= r0;
    p1 <= r1;
    pc <= cn;
    if (mem_addr_oe) addr_last <= mem_addr_out;
    if (p0 && p1 && !r0 && !r1) begin
      ref_row <= addr_seen;
      ref_cnt <= ref_cnt + 1;
    end else if ((p0 && !r0 && r1) || (p1 && !r1 && r0)) begin
      acc_row  <= addr_seen;
      acc_bank <= r0;
    end
    if (pc && !cn) acc_col <= addr_seen;
  end
endmodule : drac_dram_model
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the DRAM controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  import drac_pkg::*;
  typedef struct packed {logic bank; logic wr; logic [7:0] row; logic [7:0] col;} drac_acc_s;
  localparam drac_acc_s ACC_TAB [6] = '{'{1'h0, 1'h0, 8'h00, 8'hff}, '{1'h1, 1'h1, 8'hff, 8'h00},
    '{1'h0, 1'h1, 8'ha5, 8'h5a}, '{1'h1, 1'h0, 8'h3c, 8'hc3}, '{1'h1, 1'h0, 8'h81, 8'h7e},
    '{1'h0, 1'h1, 8'h12, 8'h34}};
  localparam logic [2:0] STRAP_TAB [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  localparam logic [7:0] DIV_TAB [7] = '{DIV_L01, DIV_L10, DIV_L11, DIV_H00, DIV_H01, DIV_H10, DIV_H11};
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] row_addr_in = 8'h00;
  logic [7:0] col_addr_in = 8'h00;
  logic chip_sel_n = 1'b1;
  logic bank_select = 1'b0;
  logic addr_latch_en = 1'b0;
  logic read_access_ctl_n = 1'b1;
  logic write_access_ctl_n = 1'b1;
  logic wait_strap = 1'b0;
  logic freq_select_0 = 1'b0;
  logic freq_select_1 = 1'b0;
  logic ext_pull = 1'b0;
  logic [7:0] exp_row = REF_ROW_RESET;
  wire logic refresh_request_line_in, mem_addr_oe, row_strobe_0_n, row_strobe_1_n, col_strobe_n, strobe_oe;
  wire logic refresh_request_line_out, refresh_request_line_oe, ready, acc_bank;
  wire logic [7:0] mem_addr_out, ref_row, acc_row, acc_col;
  int ref_cnt;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  drac_ctrl dut (.clock, .srst, .row_addr_in, .col_addr_in, .chip_sel_n, .bank_select, .addr_latch_en,
    .read_access_ctl_n, .write_access_ctl_n, .refresh_request_line_in, .wait_strap, .freq_select_0,
    .freq_select_1, .mem_addr_out, .mem_addr_oe, .row_strobe_0_n, .row_strobe_1_n, .col_strobe_n,
    .strobe_oe, .refresh_request_line_out, .refresh_request_line_oe, .ready);
  drac_dram_model u_mem (.clock, .mem_addr_out, .mem_addr_oe, .row_strobe_0_n, .row_strobe_1_n,
    .col_strobe_n, .strobe_oe, .refresh_request_line_out, .refresh_request_line_oe, .ext_pull,
    .refresh_request_line_in, .ref_cnt, .ref_row, .acc_row, .acc_col, .acc_bank);
  always #50 clock = ~clock;
  // Hang guard, well above the twelve hundred or so clocks the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // A wait strap rise reloads the row counter, so the expectation follows
  task automatic set_straps(input logic [2:0] s);
    @(negedge clock);
    if (s[2] && !wait_strap) exp_row = REF_ROW_LOAD;
    {wait_strap, freq_select_1, freq_select_0} = s;
  endtask : set_straps
  // Counts clocks until the model sees a new refresh, then checks its row
  task automatic wait_ref(input int c0, output int n);
    n = 0;
    while (ref_cnt == c0 && n < 300) begin
      @(posedge clock);
      n++;
    end
    #1;
    chk("refresh row", exp_row, ref_row);
    exp_row--;
  endtask : wait_ref
  // Latch, one idle clock, access low until ready, then release
  task automatic access(input drac_acc_s a, output int waits);
    int n;
    @(negedge clock);
    {row_addr_in, col_addr_in, bank_select} = {a.row, a.col, a.bank};
    {chip_sel_n, addr_latch_en} = 2'h1;
    @(negedge clock);
    {addr_latch_en, ext_pull} = 2'h0;
    @(negedge clock);
    {write_access_ctl_n, read_access_ctl_n} = a.wr ? 2'h1 : 2'h2;
    waits = 0;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      if (ready !== 1'b1) waits++;
      n++;
    end while (!(col_strobe_n === 1'b0 && ready === 1'b1) && n < 40);
    @(negedge clock);
    {write_access_ctl_n, read_access_ctl_n, chip_sel_n} = 3'h7;
    repeat (2) @(negedge clock);
  endtask : access
  initial begin
    int n;
    int w;
    repeat (10) @(negedge clock);
    srst = 1'b0;
    @(posedge clock);
    #1;
    chk("idle strobes", 8'h07, {5'h00, col_strobe_n, row_strobe_1_n, row_strobe_0_n});
    chk("idle ready", 8'h01, 8'(ready));
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      if (i == 4) set_straps(3'h4);
      access(ACC_TAB[i], w);
      chk("row addr", ACC_TAB[i].row, acc_row);
      chk("col addr", ACC_TAB[i].col, acc_col);
      chk("bank", 8'(ACC_TAB[i].bank), 8'(acc_bank));
      chk("waits", (i >= 4) ? 8'h01 : 8'h00, 8'(w));
    end
    $display("test access table done");
    set_straps(3'h0);
    @(negedge clock);
    {read_access_ctl_n, write_access_ctl_n} = 2'h0;
    repeat (2) @(posedge clock);
    #1;
    chk("floated oe", 8'h00, {6'h00, mem_addr_oe, strobe_oe});
    @(negedge clock);
    {read_access_ctl_n, write_access_ctl_n} = 2'h3;
    n = ref_cnt;
    repeat (200) @(negedge clock);
    chk("no internal refresh", 8'(n), 8'(ref_cnt));
    ext_pull = 1'b1;
    @(negedge clock);
    ext_pull = 1'b0;
    wait_ref(n, w);
    $display("test straps low done");
    n = ref_cnt;
    @(negedge clock);
    ext_pull = 1'b1;
    access(ACC_TAB[2], w);
    chk("access held off", 8'h01, 8'(w != 0));
    chk("held row", ACC_TAB[2].row, acc_row);
    wait_ref(n, w);
    $display("test collision done");
    for (int i = 0; i < 7; i++) begin
      set_straps(3'h0);
      repeat (8) @(negedge clock);
      set_straps(STRAP_TAB[i]);
      wait_ref(ref_cnt, n);
      wait_ref(ref_cnt, n);
      chk("refresh period", DIV_TAB[i], 8'(n));
    end
    $display("test refresh rate done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
